// ### hdl/fspc_pkg.sv
// Shared constants, offsets, field positions and state types of the flash self-program controller
package fspc_pkg;

	// Widths of the program word, address and write latch index
	localparam int ADDR_W    = 15;                    // Word address width
	localparam int DATA_W    = 14;                    // Program word width
	localparam int ROW_WORDS = 16;                    // Write latches per row
	localparam int IDX_W     = 4;                     // Latch select bits
	localparam int PADDR_W   = 12;                    // APB address width used
	localparam int LOW_W     = 8;                     // Low byte of each pair
	localparam int ADRH_W    = ADDR_W - LOW_W;        // Implemented high address bits
	localparam int DATH_W    = DATA_W - LOW_W;        // Implemented high data bits

	// Register byte offsets on APB
	localparam logic [PADDR_W-1:0] OFF_ADDR_LOW  = 12'h000;
	localparam logic [PADDR_W-1:0] OFF_ADDR_HIGH = 12'h004;
	localparam logic [PADDR_W-1:0] OFF_DATA_LOW  = 12'h008;
	localparam logic [PADDR_W-1:0] OFF_DATA_HIGH = 12'h00C;
	localparam logic [PADDR_W-1:0] OFF_CONTROL   = 12'h010;
	localparam logic [PADDR_W-1:0] OFF_UNLOCK    = 12'h014;

	// Control register field positions
	localparam int CTL_FETCH_GO   = 0;                // Start a word read
	localparam int CTL_PROG_GO    = 1;                // Start erase, load or program
	localparam int CTL_ALLOW      = 2;                // Modify allow
	localparam int CTL_ABORT      = 3;                // Modify abort flag
	localparam int CTL_LATCH_ONLY = 4;                // Latch only load
	localparam int CTL_ROW_ERASE  = 5;                // Row erase select
	localparam int CTL_CFG_SEL    = 6;                // Config space select

	// Unlock key values and blank latch content
	localparam logic [7:0]        KEY_FIRST  = 8'h55;
	localparam logic [7:0]        KEY_SECOND = 8'hAA;
	localparam logic [DATA_W-1:0] BLANK_WORD = 14'h3FFF;

	// Reset values
	localparam logic [ADDR_W-1:0] ADDR_RESET = 15'h0000;
	localparam logic [DATA_W-1:0] DATA_RESET = 14'h0000;

	// Self-modify guard codes and protected region limits
	localparam logic [1:0]        GUARD_OFF     = 2'b11;
	localparam logic [1:0]        GUARD_QUARTER = 2'b10;
	localparam logic [1:0]        GUARD_HALF    = 2'b01;
	localparam logic [ADDR_W-1:0] LIMIT_QUARTER = 15'h0200;
	localparam logic [ADDR_W-1:0] LIMIT_HALF    = 15'h0400;

	// Erase and program time
	localparam int CLK_PERIOD_PS = 5000;              // 200 MHz reference clock
	localparam int OP_TIME_NS    = 2000000;           // Typical erase or program time, 2 ms
	localparam int OP_CYCLES     = (OP_TIME_NS * 1000) / CLK_PERIOD_PS;

	// Operation sequencer states
	typedef enum logic [2:0] {
		OP_IDLE, OP_RD_SKIP, OP_RD_ARR, OP_RD_CAP, OP_NOP1, OP_NOP2, OP_BUSY
	} fspc_op_t;

	// Unlock tracker states
	typedef enum logic [1:0] {
		UNL_IDLE, UNL_GOT_FIRST, UNL_ARMED
	} fspc_unlock_t;

endpackage : fspc_pkg

// ### hdl/fspc_latch_if.sv
// Connection between the sequencer and the write latch bank
`timescale 1ns/10ps
interface fspc_latch_if #(
	parameter int DW = 14,
	parameter int N  = 16,
	parameter int IW = 4
);
	logic          load;                              // Store word in one latch
	logic          clear;                             // Return all latches to blank
	logic [IW-1:0] index;                             // Latch being loaded
	logic [DW-1:0] word;                              // Word to store
	logic [N*DW-1:0] rowData;                         // All latches, latch 0 lowest

	modport ctrl (output load, output clear, output index, output word, input rowData);
	modport bank (input load, input clear, input index, input word, output rowData);
endinterface : fspc_latch_if

// ### hdl/fspc_latch_bank.sv
// Write latch bank that stages one flash row
`timescale 1ns/10ps
module fspc_latch_bank
	import fspc_pkg::*;
#(
	parameter int N  = ROW_WORDS,
	parameter int DW = DATA_W
) (
	input  wire logic  ref_clk,
	input  wire logic  rst,
	fspc_latch_if.bank lat
);
	import fspc_pkg::*;

	logic [DW-1:0] latch_q [N];                       // Staged words

	// Load one latch, clear wins and blanks all
	always_ff @(posedge ref_clk) begin
		if (rst || lat.clear) begin
			for (int i = 0; i < N; i++) begin
				latch_q[i] <= BLANK_WORD;
			end
		end else if (lat.load) begin
			latch_q[lat.index] <= lat.word;
		end
	end

	// Flatten the bank for the array
	always_comb begin
		for (int i = 0; i < N; i++) begin
			lat.rowData[i*DW +: DW] = latch_q[i];
		end
	end
endmodule : fspc_latch_bank

// ### hdl/fspc_control.sv
// APB register file, unlock tracker and erase/program sequencer for self-programming flash
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/10ps

// Notes on behaviour
// - 14-bit data pair, 15-bit address pair
// - Address pair spans 32K words, high/low bytes
// - Internal timer sets erase and write time
// - Readout lock blocks external programmer access only
// - Only external bulk erase removes readout lock
// - Guard blocks self-modify in chosen region
// - Go bits set-only; hardware clears at end
// - Modify needs allow bit, clear at power-up (cleared by rst only; porRst alone leaves it)
// - Reset during write sets abort flag
// - Unlock register reads as zero
// - Read uses second cycle, data next
// - Data pair holds until read or write
// - Rows of sixteen 14-bit words, erase unit
// - Latches loaded only through data pair
// - 55h, AAh, then program go
// - Interrupted unlock starts nothing
// - Two forced no-ops, then ~2 ms stall
// - Latch load: two no-ops, no stall
// - Latch-only bit picks load or program
// - Latches blank after every write/erase
// - Low four address bits select latch
module fspc_control
	import fspc_pkg::*;
#(
	parameter int OP_COUNT = OP_CYCLES                // Erase/program length in cycles
) (
	input  wire logic                        ref_clk,
	input  wire logic                        rst,
	input  wire logic                        porRst,
	input  wire logic [PADDR_W-1:0]          paddr,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [31:0]                 pwdata,
	output logic [31:0]                      prdata,
	output logic                             pready,
	output logic                             pslverr,
	output logic                             cpuForceNop,
	output logic                             cpuStall,
	output logic [ADDR_W-1:0]                flashAddr,
	output logic                             flashCfgSel,
	output logic                             flashRdEn,
	input  wire logic [DATA_W-1:0]           flashRdData,
	output logic                             flashEraseEn,
	output logic                             flashProgEn,
	output logic [ROW_WORDS*DATA_W-1:0]      flashRowData,
	input  wire logic                        readoutLockPin,
	input  wire logic [1:0]                  guardPin,
	input  wire logic                        progBulkEraseReq,
	output logic                             progAccessAllow,
	output logic                             progBulkEraseGo
);
	import fspc_pkg::*;

	localparam int CNT_W = $clog2(OP_COUNT + 1);      // Timer width
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(OP_COUNT - 1);

	// Registers
	logic [LOW_W-1:0]  addrLow_q;                     // Address low byte
	logic [ADRH_W-1:0] addrHigh_q;                    // Address high bits
	logic [LOW_W-1:0]  dataLow_q;                     // Data low byte
	logic [DATH_W-1:0] dataHigh_q;                    // Data high bits
	logic              fetchGo_q;                     // Read in progress
	logic              progGo_q;                      // Modify in progress
	logic              allow_q;                       // Modify allow
	logic              abort_q;                       // Modify abort flag
	logic              latchOnly_q;                   // Latch only load
	logic              rowErase_q;                    // Row erase select
	logic              cfgSel_q;                      // Config space select
	logic              eraseKind_q;                   // Busy phase is an erase
	logic [CNT_W-1:0]  timer_q;                       // Erase/program timer
	fspc_op_t          opState_q;                     // Sequencer state
	fspc_unlock_t      unlock_q;                      // Unlock tracker state
	logic [1:0]        lockSync_q;                    // Readout lock synchroniser
	logic [3:0]        guardSync_q;                   // Guard synchroniser, two stages
	logic [1:0]        bulkSync_q;                    // Bulk erase request synchroniser

	// Bus decode
	logic apbSetup;                                   // First cycle of a transfer
	logic apbWr;                                      // Write taking effect
	logic mapped;                                     // Address hits a register
	logic ctlWr;                                      // Control register write
	logic keyWr;                                      // Unlock register write
	logic goRequest;                                  // Write that sets program go
	logic goAccepted;                                 // Program go really starts
	logic [ADDR_W-1:0] fullAddr;                      // Address pair
	logic [DATA_W-1:0] fullData;                      // Data pair
	fspc_latch_if #(.DW(DATA_W), .N(ROW_WORDS), .IW(IDX_W)) lat ();

	// Guarded region check for the current row
	function automatic logic guardBlocks(input logic [1:0] code, input logic [ADDR_W-1:0] adr);
		case (code)
			GUARD_OFF:     guardBlocks = 1'b0;
			GUARD_QUARTER: guardBlocks = (adr < LIMIT_QUARTER);
			GUARD_HALF:    guardBlocks = (adr < LIMIT_HALF);
			default:       guardBlocks = 1'b1;
		endcase
	endfunction : guardBlocks

	assign apbSetup  = psel && !penable;
	assign apbWr     = psel && penable && pwrite;
	assign pready    = psel && penable;               // Zero wait states
	assign mapped    = (paddr == OFF_ADDR_LOW) || (paddr == OFF_ADDR_HIGH) || (paddr == OFF_DATA_LOW)
	                || (paddr == OFF_DATA_HIGH) || (paddr == OFF_CONTROL) || (paddr == OFF_UNLOCK);
	assign ctlWr     = apbWr && (paddr == OFF_CONTROL);
	assign keyWr     = apbWr && (paddr == OFF_UNLOCK);
	assign goRequest = ctlWr && pwdata[CTL_PROG_GO] && !progGo_q;
	assign goAccepted = goRequest && (unlock_q == UNL_ARMED) && allow_q && (opState_q == OP_IDLE);
	assign fullAddr  = {addrHigh_q, addrLow_q};
	assign fullData  = {dataHigh_q, dataLow_q};

	// Two-stage synchronisers for configuration and programmer pins
	always_ff @(posedge ref_clk) begin
		if (porRst) begin
			lockSync_q  <= 2'b11;
			guardSync_q <= 4'h0;
			bulkSync_q  <= 2'b00;
		end else begin
			lockSync_q  <= {lockSync_q[0], readoutLockPin};
			guardSync_q <= {guardSync_q[1:0], guardPin};
			bulkSync_q  <= {bulkSync_q[0], progBulkEraseReq};
		end
	end

	// Programmer side: lock denies access, bulk erase always passes
	assign progAccessAllow = !lockSync_q[1];
	assign progBulkEraseGo = bulkSync_q[1];

	// APB read data and error, captured in the setup cycle
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (apbSetup) begin
			pslverr <= !mapped;
			prdata  <= 32'h0000_0000;
			case (paddr)
				OFF_ADDR_LOW:  prdata[LOW_W-1:0]  <= addrLow_q;
				OFF_ADDR_HIGH: prdata[ADRH_W-1:0] <= addrHigh_q;
				OFF_DATA_LOW:  prdata[LOW_W-1:0]  <= dataLow_q;
				OFF_DATA_HIGH: prdata[DATH_W-1:0] <= dataHigh_q;
				OFF_CONTROL: begin
					prdata[CTL_FETCH_GO]   <= fetchGo_q;
					prdata[CTL_PROG_GO]    <= progGo_q;
					prdata[CTL_ALLOW]      <= allow_q;
					prdata[CTL_ABORT]      <= abort_q;
					prdata[CTL_LATCH_ONLY] <= latchOnly_q;
					prdata[CTL_ROW_ERASE]  <= rowErase_q;
					prdata[CTL_CFG_SEL]    <= cfgSel_q;
				end
				default: prdata <= 32'h0000_0000;     // Unlock and unmapped read zero
			endcase
		end
	end

	// Address pair
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			addrLow_q  <= ADDR_RESET[LOW_W-1:0];
			addrHigh_q <= ADDR_RESET[ADDR_W-1:LOW_W];
		end else if (apbWr && paddr == OFF_ADDR_LOW) begin
			addrLow_q  <= pwdata[LOW_W-1:0];
		end else if (apbWr && paddr == OFF_ADDR_HIGH) begin
			addrHigh_q <= pwdata[ADRH_W-1:0];
		end
	end

	// Data pair: holds last read word unless software writes it
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dataLow_q  <= DATA_RESET[LOW_W-1:0];
			dataHigh_q <= DATA_RESET[DATA_W-1:LOW_W];
		end else if (opState_q == OP_RD_CAP) begin
			{dataHigh_q, dataLow_q} <= flashRdData;
		end else if (apbWr && paddr == OFF_DATA_LOW) begin
			dataLow_q  <= pwdata[LOW_W-1:0];
		end else if (apbWr && paddr == OFF_DATA_HIGH) begin
			dataHigh_q <= pwdata[DATH_W-1:0];
		end
	end

	// Plain control bits; allow clears on rst, porRst alone leaves it
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			allow_q     <= 1'b0;
			latchOnly_q <= 1'b0;
			rowErase_q  <= 1'b0;
			cfgSel_q    <= 1'b0;
		end else if (ctlWr) begin
			allow_q     <= pwdata[CTL_ALLOW];
			latchOnly_q <= pwdata[CTL_LATCH_ONLY];
			rowErase_q  <= pwdata[CTL_ROW_ERASE];
			cfgSel_q    <= pwdata[CTL_CFG_SEL];
		end
	end

	// Abort flag survives device reset; set if reset cuts a modify
	always_ff @(posedge ref_clk) begin
		if (porRst) begin
			abort_q <= 1'b0;
		end else if (rst) begin
			if (opState_q == OP_BUSY || opState_q == OP_NOP1 || opState_q == OP_NOP2) begin
				abort_q <= 1'b1;
			end
		end else if (ctlWr && !pwdata[CTL_ABORT]) begin
			abort_q <= 1'b0;                            // Software acknowledge
		end
	end

	// Unlock tracker: exact 55h, AAh, program go; any other write disarms, a repeated 55h restarts, reads leave it
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			unlock_q <= UNL_IDLE;
		end else if (apbWr) begin
			case (unlock_q)
				UNL_IDLE: begin
					if (keyWr && pwdata[LOW_W-1:0] == KEY_FIRST) begin
						unlock_q <= UNL_GOT_FIRST;
					end
				end
				UNL_GOT_FIRST: begin
					if (keyWr && pwdata[LOW_W-1:0] == KEY_SECOND) begin
						unlock_q <= UNL_ARMED;
					end else if (keyWr && pwdata[LOW_W-1:0] == KEY_FIRST) begin
						unlock_q <= UNL_GOT_FIRST;
					end else begin
						unlock_q <= UNL_IDLE;
					end
				end
				default: begin
					unlock_q <= UNL_IDLE;                   // Go write consumes arming
				end
			endcase
		end
	end

	// Fetch go: set-only by software, cleared when the word lands
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			fetchGo_q <= 1'b0;
		end else if (opState_q == OP_RD_CAP) begin
			fetchGo_q <= 1'b0;
		end else if (ctlWr && pwdata[CTL_FETCH_GO] && opState_q == OP_IDLE && !goAccepted) begin
			fetchGo_q <= 1'b1;                          // Zero writes ignored
		end
	end

	// Program go: set only through a full unlock with allow
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			progGo_q <= 1'b0;
		end else if (goAccepted) begin
			progGo_q <= 1'b1;
		end else if ((opState_q == OP_NOP2 && (latchOnly_q || guardBlocks(guardSync_q[3:2], fullAddr)))
		          || (opState_q == OP_BUSY && timer_q == CNT_LAST)) begin
			progGo_q <= 1'b0;
		end
	end

	// Operation sequencer
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			opState_q   <= OP_IDLE;
			eraseKind_q <= 1'b0;
		end else begin
			case (opState_q)
				OP_IDLE: begin
					if (goAccepted) begin
						opState_q <= OP_NOP1;
					end else if (ctlWr && pwdata[CTL_FETCH_GO]) begin
						opState_q <= OP_RD_SKIP;
					end
				end
				OP_RD_SKIP: opState_q <= OP_RD_ARR;
				OP_RD_ARR:  opState_q <= OP_RD_CAP;
				OP_RD_CAP:  opState_q <= OP_IDLE;
				OP_NOP1:    opState_q <= OP_NOP2;
				OP_NOP2: begin
					eraseKind_q <= rowErase_q;
					if (latchOnly_q || guardBlocks(guardSync_q[3:2], fullAddr)) begin
						opState_q <= OP_IDLE;
					end else begin
						opState_q <= OP_BUSY;
					end
				end
				OP_BUSY: begin
					if (timer_q == CNT_LAST) begin
						opState_q <= OP_IDLE;
					end
				end
				default: opState_q <= OP_IDLE;
			endcase
		end
	end

	// Internal erase/program timer
	always_ff @(posedge ref_clk) begin
		if (rst || opState_q != OP_BUSY) begin
			timer_q <= '0;
		end else begin
			timer_q <= timer_q + CNT_W'(1);
		end
	end

	// Latch bank control: load after the forced no-ops, blank after modify
	assign lat.load  = (opState_q == OP_NOP2) && latchOnly_q && !guardBlocks(guardSync_q[3:2], fullAddr);
	assign lat.index = addrLow_q[IDX_W-1:0];
	assign lat.word  = fullData;
	assign lat.clear = (opState_q == OP_BUSY) && (timer_q == CNT_LAST);

	fspc_latch_bank #(
		.N  (ROW_WORDS),
		.DW (DATA_W)
	) u_latches (
		.ref_clk (ref_clk),
		.rst     (rst),
		.lat     (lat)
	);

	// Core and array strobes
	assign cpuForceNop  = (opState_q == OP_NOP1) || (opState_q == OP_NOP2)
	                   || (opState_q == OP_RD_SKIP) || (opState_q == OP_RD_ARR);
	assign cpuStall     = (opState_q == OP_BUSY);
	assign flashAddr    = {fullAddr[ADDR_W-1:IDX_W], (opState_q == OP_BUSY) ? {IDX_W{1'b0}} : fullAddr[IDX_W-1:0]};
	assign flashCfgSel  = cfgSel_q;
	assign flashRdEn    = (opState_q == OP_RD_ARR);
	assign flashEraseEn = (opState_q == OP_BUSY) && eraseKind_q;
	assign flashProgEn  = (opState_q == OP_BUSY) && !eraseKind_q;
	assign flashRowData = lat.rowData;

	// Assertions
	sequence s_read_slots;
		!flashRdEn ##1 flashRdEn ##1 !flashRdEn;
	endsequence

	sequence s_two_nops;
		cpuForceNop[*2];
	endsequence

	a_read_timing: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(fetchGo_q) |-> s_read_slots ##1 !fetchGo_q)
		else $error("read slot timing wrong");

	a_read_data: assert property (@(posedge ref_clk) disable iff (rst)
		opState_q == OP_RD_CAP |=> fullData == $past(flashRdData))
		else $error("read word not captured");

	a_go_unlocked: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(progGo_q) |-> $past(unlock_q) == UNL_ARMED && $past(allow_q))
		else $error("program go without unlock");

	a_forced_nops: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(progGo_q) |-> s_two_nops ##1 !cpuForceNop)
		else $error("forced no-ops missing");

	a_load_nostall: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(progGo_q) && latchOnly_q |-> s_two_nops ##1 (!cpuStall && !progGo_q))
		else $error("latch load stalled");

	a_stall_start: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(cpuStall) |-> timer_q == '0 && progGo_q)
		else $error("stall began with timer running");

	a_stall_end: assert property (@(posedge ref_clk) disable iff (rst)
		cpuStall && timer_q == CNT_LAST |=> !cpuStall && !progGo_q)
		else $error("stall did not end on time");

	a_blank_after: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(cpuStall) |-> lat.rowData == {ROW_WORDS{BLANK_WORD}})
		else $error("latches not blank after modify");

	a_unlock_break: assert property (@(posedge ref_clk) disable iff (rst)
		unlock_q == UNL_GOT_FIRST && apbWr && !keyWr |=> unlock_q == UNL_IDLE)
		else $error("broken unlock kept state");

	a_key_zero: assert property (@(posedge ref_clk) disable iff (rst)
		apbSetup && !pwrite && paddr == OFF_UNLOCK |=> prdata == 32'h0000_0000)
		else $error("unlock register read nonzero");

	a_abort_flag: assert property (@(posedge ref_clk) disable iff (porRst)
		rst && opState_q == OP_BUSY |=> abort_q)
		else $error("abort flag not set");

endmodule : fspc_control

// ### verif/fspc_tb.sv
// Self-checking bench for the flash self-program controller
`timescale 1ns/10ps
module tb;
	import fspc_pkg::*;
	localparam int OPN = 12;                          // Shortened erase/program length
	localparam logic [32:0] MALL = 33'h1_FFFF_FFFF;   // Compare every bit
	logic ref_clk = 0, rst = 1, porRst = 1, psel = 0, penable = 0, pwrite = 0;
	logic readoutLockPin = 0, progBulkEraseReq = 0;
	logic [1:0] guardPin = 2'b11;
	logic [PADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic pready, pslverr, cpuForceNop, cpuStall, flashCfgSel, flashRdEn, flashEraseEn, flashProgEn;
	logic progAccessAllow, progBulkEraseGo;
	logic [ADDR_W-1:0] flashAddr, rA;
	logic [DATA_W-1:0] flashRdData, rD, mem;
	logic [ROW_WORDS*DATA_W-1:0] flashRowData;
	logic [32:0] expQ[$], mskQ[$], eNote, mNote;
	int failures = 0, checks_done = 0;
	// Array model: word derived from the address
	assign flashRdData = flashAddr[13:0] ^ 14'h2A5C;
	always #2.5 ref_clk = ~ref_clk;
	fspc_control #(.OP_COUNT(OPN)) i_fspc_control (.ref_clk(ref_clk), .rst(rst), .porRst(porRst), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpuForceNop(cpuForceNop), .cpuStall(cpuStall), .flashAddr(flashAddr),
		.flashCfgSel(flashCfgSel), .flashRdEn(flashRdEn), .flashRdData(flashRdData), .flashEraseEn(flashEraseEn),
		.flashProgEn(flashProgEn), .flashRowData(flashRowData), .readoutLockPin(readoutLockPin),
		.guardPin(guardPin), .progBulkEraseReq(progBulkEraseReq), .progAccessAllow(progAccessAllow),
		.progBulkEraseGo(progBulkEraseGo));
	// Closing report and verdict
	task conclude;
		if (expQ.size() != 0) failures++;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : conclude
	// One comparison
	task chk(input string n, input logic [223:0] e, input logic [223:0] s);
		checks_done++;
		if (e !== s) begin
			$display("[FAIL] %s expected %h seen %h", n, e, s);
			failures++;
		end
	endtask : chk
	// APB transfer, held until pready at a rising edge
	task xfer(input logic w, input logic [PADDR_W-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (n > 20) begin
				failures++;
				conclude();
			end
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task wr(input logic [PADDR_W-1:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	// Read: note the expectation, the monitor compares
	task rd(input logic [PADDR_W-1:0] a, input logic [32:0] e, input logic [32:0] m);
		expQ.push_back(e);
		mskQ.push_back(m);
		xfer(1'b0, a, 32'h0000_0000);
	endtask : rd
	task ulk(input logic [31:0] ctl);
		wr(OFF_UNLOCK, 32'h0000_0055);
		wr(OFF_UNLOCK, 32'h0000_00AA);
		wr(OFF_CONTROL, ctl);
	endtask : ulk
	// Bounded wait on the stall output
	task waitStall(input logic want);
		int n;
		n = 0;
		while (cpuStall !== want) begin
			@(posedge ref_clk);
			n++;
			if (n > 100) begin
				failures++;
				conclude();
			end
		end
	endtask : waitStall
	// Read monitor: oldest note against the answer
	always @(posedge ref_clk) begin
		if (psel && penable && pready && !pwrite) begin
			eNote = expQ.pop_front();
			mNote = mskQ.pop_front();
			chk("read", eNote & mNote, {pslverr, prdata} & mNote);
		end
	end
	// Main sequence
	initial begin
		void'($urandom(32'h5e7325b2));
		rA = 15'($urandom);
		rD = 14'($urandom);
		mem = rA[13:0] ^ 14'h2A5C;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		porRst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rd(OFF_CONTROL, 33'h0_0000_0000, MALL);
		wr(OFF_UNLOCK, 32'h0000_0055);
		rd(OFF_UNLOCK, 33'h0_0000_0000, MALL);
		rd(12'h018, 33'h1_0000_0000, MALL);
		wr(OFF_ADDR_LOW, {24'h00_0000, rA[7:0]});
		wr(OFF_ADDR_HIGH, {25'h000_0000, rA[14:8]});
		rd(OFF_ADDR_HIGH, {26'h000_0000, rA[14:8]}, MALL);
		wr(OFF_CONTROL, 32'h0000_0040);
		@(negedge ref_clk);
		chk("cfgsel", 224'(1), 224'(flashCfgSel));
		wr(OFF_CONTROL, 32'h0000_0001);
		@(negedge ref_clk);
		chk("cfgsel", 224'(0), 224'(flashCfgSel));
		chk("nop", 224'(1), 224'(cpuForceNop));
		@(negedge ref_clk);
		chk("rden", 224'(1), 224'(flashRdEn));
		repeat (3) @(posedge ref_clk);
		rd(OFF_DATA_LOW, {25'h000_0000, mem[7:0]}, MALL);
		rd(OFF_DATA_HIGH, {27'h000_0000, mem[13:8]}, MALL);
		rd(OFF_CONTROL, 33'h0_0000_0000, MALL);
		wr(OFF_ADDR_LOW, {24'h00_0000, ~rA[7:0]});
		rd(OFF_DATA_LOW, {25'h000_0000, mem[7:0]}, MALL);
		wr(OFF_ADDR_LOW, {24'h00_0000, rA[7:0]});
		wr(OFF_DATA_LOW, {24'h00_0000, rD[7:0]});
		wr(OFF_DATA_HIGH, {26'h000_0000, rD[13:8]});
		rd(OFF_DATA_HIGH, {27'h000_0000, rD[13:8]}, MALL);
		wr(OFF_CONTROL, 32'h0000_0014);
		wr(OFF_CONTROL, 32'h0000_0016);
		rd(OFF_CONTROL, 33'h0_0000_0014, MALL);
		chk("row", {ROW_WORDS{BLANK_WORD}}, flashRowData);
		ulk(32'h0000_0016);
		repeat (4) @(posedge ref_clk);
		chk("latch", 224'(rD), 224'(flashRowData[rA[3:0]*DATA_W +: DATA_W]));
		chk("stall", 224'(0), 224'(cpuStall));
		rd(OFF_CONTROL, 33'h0_0000_0014, MALL);
		wr(OFF_DATA_LOW, {24'h00_0000, ~rD[7:0]});
		wr(OFF_UNLOCK, 32'h0000_0055);
		wr(OFF_DATA_HIGH, 32'h0000_0000);
		wr(OFF_UNLOCK, 32'h0000_00AA);
		wr(OFF_CONTROL, 32'h0000_0016);
		repeat (4) @(posedge ref_clk);
		chk("latch", 224'(rD), 224'(flashRowData[rA[3:0]*DATA_W +: DATA_W]));
		ulk(32'h0000_0006);
		waitStall(1'b1);
		chk("prog", 224'(1), 224'(flashProgEn));
		chk("addr", 224'({rA[14:4], 4'h0}), 224'(flashAddr));
		wr(OFF_CONTROL, 32'h0000_0004);
		rd(OFF_CONTROL, 33'h0_0000_0006, MALL);
		waitStall(1'b0);
		chk("row", {ROW_WORDS{BLANK_WORD}}, flashRowData);
		rd(OFF_CONTROL, 33'h0_0000_0004, MALL);
		ulk(32'h0000_0026);
		waitStall(1'b1);
		chk("erase", 224'(1), 224'(flashEraseEn));
		waitStall(1'b0);
		guardPin <= 2'b00;
		repeat (3) @(posedge ref_clk);
		ulk(32'h0000_0016);
		repeat (4) @(posedge ref_clk);
		chk("row", {ROW_WORDS{BLANK_WORD}}, flashRowData);
		guardPin <= 2'b11;
		repeat (3) @(posedge ref_clk);
		ulk(32'h0000_0006);
		waitStall(1'b1);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		rd(OFF_CONTROL, 33'h0_0000_0008, 33'h0_0000_0008);
		readoutLockPin <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk("access", 224'(0), 224'(progAccessAllow));
		readoutLockPin <= 1'b0;
		progBulkEraseReq <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk("access", 224'(1), 224'(progAccessAllow));
		chk("bulk", 224'(1), 224'(progBulkEraseGo));
		progBulkEraseReq <= 1'b0;
		repeat (2) @(posedge ref_clk);
		conclude();
	end
endmodule : tb
